// *** pkg/aer_regs.svh ***
`ifndef AER_REGS_SVH
`define AER_REGS_SVH
// register byte offsets
`define AER_OFF_SEV 12'h10c
`define AER_OFF_CSTS 12'h110
`define AER_OFF_CMSK 12'h114
`define AER_OFF_CAP 12'h118
`define AER_OFF_HL0 12'h11c
`define AER_OFF_HL3 12'h128
`define AER_OFF_ISTS 12'h130
`define AER_OFF_IMSK 12'h134
// severity register layout and reset
`define AER_SEV_WMASK 32'h003ff031
`define AER_SEV_RST 32'h00062031
`define AER_SEV_SD_POS 5'h05
// correctable status and mask layout
`define AER_COR_WMASK 32'h000031c1
`define AER_CSTS_RST 32'h00000000
`define AER_CMSK_RST 32'h00002000
`define AER_COR_RXERR 0
`define AER_COR_BADTLP 6
`define AER_COR_BADDLLP 7
`define AER_COR_ROLL 8
`define AER_COR_RTO 12
`define AER_COR_ANF 13
// capabilities and control fields
`define AER_CAP_FEP_HI 4
`define AER_CAP_GEN_CAP 5
`define AER_CAP_GEN_EN 6
`define AER_CAP_CHK_CAP 7
`define AER_CAP_CHK_EN 8
`define AER_CAP_WMASK 32'h00000140
// interrupt status bits
`define AER_IRQ_COR 0
`define AER_IRQ_NF 1
`define AER_IRQ_FAT 2
`define AER_IRQ_LOG 3
`define AER_IRQ_WMASK 32'h0000000f
`endif

// *** pkg/aer_pkg.sv ***
package aer_pkg;
  // one register access taken from the bus
  typedef struct packed {
    logic valid;
    logic we;
    logic [11:0] adr;
    logic [3:0] sel;
    logic [31:0] wdata;
  } reg_req_t;
  // correctable error event pulses from link and transaction layers
  typedef struct packed {
    logic rx_err;
    logic bad_tlp;
    logic bad_dllp;
    logic replay_roll;
    logic replay_tmo;
    logic advisory_nf;
  } cor_evt_t;
  // uncorrectable error report, already filtered by its own mask
  typedef struct packed {
    logic valid;
    logic [4:0] pos;
    logic [127:0] hdr;
  } unc_rpt_t;
  // error message requests toward the root complex
  typedef struct packed {
    logic cor;
    logic nonfatal;
    logic fatal;
  } err_msg_t;
endpackage : aer_pkg

// *** logic/wb_reg_port.sv ***
`timescale 1ns/1ps
module wb_reg_port (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output aer_pkg::reg_req_t req,
  input wire logic [31:0] rdata
);
  logic ack_ff;
  logic [31:0] dat_ff;
  // one access per cycle, never while the ack of the last is up
  assign req.valid = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign req.we = wb_we_i;
  assign req.adr = {wb_adr_i[11:2], 2'h0};
  assign req.sel = wb_sel_i;
  assign req.wdata = wb_dat_i;
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;
  // ack one cycle after the request, read data captured with it
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0;
    end
    else
    begin
      ack_ff <= req.valid;
      dat_ff <= (req.valid & ~wb_we_i) ? rdata : 32'h0;
    end
  end
endmodule : wb_reg_port

// *** logic/header_log.sv ***
`timescale 1ns/1ps
module header_log #(
  parameter int WORDS = 4
) (
  input wire logic clk,
  input wire logic sticky_rst_n,
  input wire logic capture,
  input wire logic [WORDS*32-1:0] hdr,
  input wire logic [1:0] rd_idx,
  output logic [31:0] rd_word
);
  logic [31:0] log_ff [WORDS];
  // header byte 0 arrives in hdr[7:0]; each word keeps bytes big-endian
  genvar w;
  generate
    for (w = 0; w < WORDS; w++)
    begin : g_word
      always_ff @(posedge clk)
      begin
        if (!sticky_rst_n)
          log_ff[w] <= 32'h0;
        else if (capture)
          log_ff[w] <= {hdr[w*32 +: 8], hdr[w*32+8 +: 8],
                        hdr[w*32+16 +: 8], hdr[w*32+24 +: 8]};
      end
    end
  endgenerate
  assign rd_word = log_ff[rd_idx];
endmodule : header_log

// *** logic/aer_severity_correctable_regs.sv ***
// Our own choice: the Wishbone slave port.
`timescale 1ns/1ps
`include "aer_regs.svh"
// Contract
// - severity bits 0,4,5,12-21 are writable sticky; 1 fatal, 0 non-fatal
// - severity resets fatal for bits 0,4,5,13,17,18; others non-fatal
// - surprise down severity only used on a downstream port
// - receiver error sets status bit 0; status sticky, write one clears
// - bad packet sets bit 6, bad link packet sets bit 7
// - replay counter rollover sets status bit 8
// - replay timeout sets bit 12, advisory non-fatal sets bit 13
// - masked correctable error still sets its status bit but is neither header-logged nor messaged
// - advisory non-fatal mask bit 13 resets to one
// - other correctable mask bits are writable sticky, reset zero
// - bits 4:0 hold first uncorrectable error position, sticky, reset zero
// - bit 5 reads one: end-to-end crc generation capable
// - bit 6 enables crc generation, sticky, resets zero
// - bit 7 reads one: end-to-end crc check capable
// - bit 8 enables crc checking, sticky, resets zero
// - header log keeps four big-endian header words, read-only, sticky
module aer_severity_correctable_regs #(
  parameter bit DOWNSTREAM_PORT = 1'b1,
  parameter int LOG_WORDS = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sticky_rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input aer_pkg::cor_evt_t cor_evt,
  input wire logic [127:0] cor_hdr,
  input aer_pkg::unc_rpt_t unc_rpt,
  input wire logic unc_pending,
  output aer_pkg::err_msg_t err_msg,
  output logic ecrc_gen_en,
  output logic ecrc_chk_en,
  output logic irq
);
  aer_pkg::reg_req_t req;
  logic [31:0] rdata;
  logic [31:0] hl_word;

  // sticky registers
  logic [31:0] sev_ff;
  logic [31:0] csts_ff;
  logic [31:0] cmsk_ff;
  logic [4:0] fep_ff;
  logic fep_lock_ff;
  logic gen_en_ff;
  logic chk_en_ff;
  // ordinary registers
  logic [31:0] ists_ff;
  logic [31:0] imsk_ff;
  aer_pkg::err_msg_t msg_ff;

  logic [31:0] nxt_sev;
  logic [31:0] nxt_csts;
  logic [31:0] nxt_cmsk;
  logic [31:0] nxt_ists;
  logic [31:0] nxt_imsk;
  logic [4:0] nxt_fep;
  logic nxt_fep_lock;
  logic nxt_gen_en;
  logic nxt_chk_en;
  aer_pkg::err_msg_t nxt_msg;

  // bus slave front end
  wb_reg_port u_port (
    .clk(clk),
    .rst_n(rst_n),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .req(req),
    .rdata(rdata)
  );

  // address decode
  wire hit_sev = req.adr == `AER_OFF_SEV;
  wire hit_csts = req.adr == `AER_OFF_CSTS;
  wire hit_cmsk = req.adr == `AER_OFF_CMSK;
  wire hit_cap = req.adr == `AER_OFF_CAP;
  wire hit_hl = (req.adr >= `AER_OFF_HL0) && (req.adr <= `AER_OFF_HL3);
  wire hit_ists = req.adr == `AER_OFF_ISTS;
  wire hit_imsk = req.adr == `AER_OFF_IMSK;
  wire wr = req.valid & req.we;
  wire [11:0] hl_off = req.adr - `AER_OFF_HL0;
  wire [1:0] hl_idx = hl_off[3:2];

  // byte enables widened to a bit mask
  wire [31:0] be_mask = {{8{req.sel[3]}}, {8{req.sel[2]}},
                         {8{req.sel[1]}}, {8{req.sel[0]}}};
  wire [31:0] wd_be = req.wdata & be_mask;

  // writable bits only; reserved and read-only bits never change
  wire [31:0] sev_wm = be_mask & `AER_SEV_WMASK;
  wire [31:0] cmsk_wm = be_mask & `AER_COR_WMASK;
  wire [31:0] cap_wm = be_mask & `AER_CAP_WMASK;
  wire [31:0] imsk_wm = be_mask & `AER_IRQ_WMASK;

  // write-one-to-clear strobes
  wire [31:0] csts_clr = (wr && hit_csts) ? (wd_be & `AER_COR_WMASK) : 32'h0;
  wire [31:0] ists_clr = (wr && hit_ists) ? (wd_be & `AER_IRQ_WMASK) : 32'h0;

  // correctable events placed at their status positions
  logic [31:0] cor_set;
  always_comb
  begin
    cor_set = 32'h0;
    cor_set[`AER_COR_RXERR] = cor_evt.rx_err;
    cor_set[`AER_COR_BADTLP] = cor_evt.bad_tlp;
    cor_set[`AER_COR_BADDLLP] = cor_evt.bad_dllp;
    cor_set[`AER_COR_ROLL] = cor_evt.replay_roll;
    cor_set[`AER_COR_RTO] = cor_evt.replay_tmo;
    cor_set[`AER_COR_ANF] = cor_evt.advisory_nf;
  end

  // unmasked correctable events raise a message, masked ones stay silent
  wire [31:0] cor_unmasked = cor_set & ~cmsk_ff;
  wire cor_report = |cor_unmasked;
  wire cor_log = cor_unmasked[`AER_COR_BADTLP] & ~fep_lock_ff;

  // uncorrectable severity lookup by bit position
  wire [31:0] sev_classes = `AER_SEV_WMASK;
  wire pos_valid = sev_classes[unc_rpt.pos];
  wire pos_is_sd = unc_rpt.pos == `AER_SEV_SD_POS;
  // upstream port ignores surprise down and its severity bit
  wire pos_usable = pos_valid & (DOWNSTREAM_PORT | ~pos_is_sd);
  wire unc_fatal = sev_ff[unc_rpt.pos];
  wire unc_take = unc_rpt.valid & pos_usable;

  // first error capture: only when no earlier error is still pending
  wire fep_capture = unc_take & ~fep_lock_ff;
  wire log_capture = fep_capture | cor_log;
  wire [127:0] log_hdr = fep_capture ? unc_rpt.hdr : cor_hdr;

  // header log storage
  header_log #(
    .WORDS(LOG_WORDS)
  ) u_log (
    .clk(clk),
    .sticky_rst_n(sticky_rst_n),
    .capture(log_capture),
    .hdr(log_hdr),
    .rd_idx(hl_idx),
    .rd_word(hl_word)
  );

  // next values of the sticky severity and mask registers
  always_comb
  begin
    nxt_sev = sev_ff;
    nxt_cmsk = cmsk_ff;
    if (wr && hit_sev)
      nxt_sev = (sev_ff & ~sev_wm) | (req.wdata & sev_wm);
    if (wr && hit_cmsk)
      nxt_cmsk = (cmsk_ff & ~cmsk_wm) | (req.wdata & cmsk_wm);
  end

  // correctable status: a new event wins over a clear in the same cycle
  assign nxt_csts = (csts_ff & ~csts_clr) | cor_set;

  // capabilities and control next values
  always_comb
  begin
    nxt_gen_en = gen_en_ff;
    nxt_chk_en = chk_en_ff;
    if (wr && hit_cap && cap_wm[`AER_CAP_GEN_EN])
      nxt_gen_en = req.wdata[`AER_CAP_GEN_EN];
    if (wr && hit_cap && cap_wm[`AER_CAP_CHK_EN])
      nxt_chk_en = req.wdata[`AER_CAP_CHK_EN];
  end

  // pointer locks on the first error and frees once status is cleared
  always_comb
  begin
    nxt_fep = fep_ff;
    nxt_fep_lock = fep_lock_ff;
    if (fep_capture)
    begin
      nxt_fep = unc_rpt.pos;
      nxt_fep_lock = 1'b1;
    end
    else if (!unc_pending)
      nxt_fep_lock = 1'b0;
  end

  // message requests toward the root complex
  always_comb
  begin
    nxt_msg.cor = cor_report;
    nxt_msg.nonfatal = unc_take & ~unc_fatal;
    nxt_msg.fatal = unc_take & unc_fatal;
  end

  // interrupt status set by messages and log captures
  logic [31:0] irq_set;
  always_comb
  begin
    irq_set = 32'h0;
    irq_set[`AER_IRQ_COR] = nxt_msg.cor;
    irq_set[`AER_IRQ_NF] = nxt_msg.nonfatal;
    irq_set[`AER_IRQ_FAT] = nxt_msg.fatal;
    irq_set[`AER_IRQ_LOG] = log_capture;
  end
  assign nxt_ists = (ists_ff & ~ists_clr) | irq_set;
  assign nxt_imsk = (wr && hit_imsk) ? ((imsk_ff & ~imsk_wm) | (req.wdata & imsk_wm))
                                     : imsk_ff;

  // sticky state: only the sticky reset returns it to defaults
  always_ff @(posedge clk)
  begin
    if (!sticky_rst_n)
    begin
      sev_ff <= `AER_SEV_RST;
      csts_ff <= `AER_CSTS_RST;
      cmsk_ff <= `AER_CMSK_RST;
      fep_ff <= 5'h0;
      fep_lock_ff <= 1'b0;
      gen_en_ff <= 1'b0;
      chk_en_ff <= 1'b0;
    end
    else
    begin
      sev_ff <= nxt_sev;
      csts_ff <= nxt_csts;
      cmsk_ff <= nxt_cmsk;
      fep_ff <= nxt_fep;
      fep_lock_ff <= nxt_fep_lock;
      gen_en_ff <= nxt_gen_en;
      chk_en_ff <= nxt_chk_en;
    end
  end

  // ordinary state: message pulses and interrupt registers
  always_ff @(posedge clk)
  begin
    if (!rst_n || !sticky_rst_n)
    begin
      msg_ff <= '0;
      ists_ff <= 32'h0;
      imsk_ff <= 32'h0;
    end
    else
    begin
      msg_ff <= nxt_msg;
      ists_ff <= nxt_ists;
      imsk_ff <= nxt_imsk;
    end
  end

  // capabilities and control as read back
  logic [31:0] cap_rd;
  always_comb
  begin
    cap_rd = 32'h0;
    cap_rd[`AER_CAP_FEP_HI:0] = fep_ff;
    cap_rd[`AER_CAP_GEN_CAP] = 1'b1;
    cap_rd[`AER_CAP_GEN_EN] = gen_en_ff;
    cap_rd[`AER_CAP_CHK_CAP] = 1'b1;
    cap_rd[`AER_CAP_CHK_EN] = chk_en_ff;
  end

  // read mux; unmapped addresses read zero
  assign rdata = hit_sev ? (sev_ff & `AER_SEV_WMASK) :
                 hit_csts ? (csts_ff & `AER_COR_WMASK) :
                 hit_cmsk ? (cmsk_ff & `AER_COR_WMASK) :
                 hit_cap ? cap_rd :
                 hit_hl ? hl_word :
                 hit_ists ? ists_ff :
                 hit_imsk ? imsk_ff :
                 32'h0;

  // outputs
  assign err_msg = msg_ff;
  assign ecrc_gen_en = gen_en_ff;
  assign ecrc_chk_en = chk_en_ff;
  assign irq = |(ists_ff & imsk_ff);
endmodule : aer_severity_correctable_regs

// *** testbench/aer_regs_props.sv ***
`timescale 1ns/1ps
module aer_regs_props #(
  parameter bit DOWNSTREAM_PORT = 1'b1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sticky_rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input aer_pkg::cor_evt_t cor_evt,
  input aer_pkg::unc_rpt_t unc_rpt,
  input aer_pkg::err_msg_t err_msg,
  input wire logic ecrc_gen_en,
  input wire logic ecrc_chk_en
);
  // a write request aimed at the capabilities and control word
  wire wr_cap = wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i[11:2] == 10'h046;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n || !sticky_rst_n);
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged next cycle");
  a_ack_drop: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_rdata_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside ack");
  a_cor_cause: assert property (!(|cor_evt) |=> !err_msg.cor)
    else $error("correctable message without event");
  a_unc_cause: assert property (!unc_rpt.valid |=> !err_msg.fatal && !err_msg.nonfatal)
    else $error("uncorrectable message without report");
  a_unc_class: assert property (unc_rpt.valid && unc_rpt.pos == 5'h00 |=>
    err_msg.fatal != err_msg.nonfatal)
    else $error("class report not sent as exactly one severity");
  a_sd_port: assert property (unc_rpt.valid && unc_rpt.pos == 5'h05 |=>
    (err_msg.fatal || err_msg.nonfatal) == DOWNSTREAM_PORT)
    else $error("surprise down handling wrong for port kind");
  a_gen_cause: assert property ($changed(ecrc_gen_en) |-> $past(wr_cap) || $past(wr_cap, 2))
    else $error("generation enable changed without write");
  a_chk_cause: assert property ($changed(ecrc_chk_en) |-> $past(wr_cap) || $past(wr_cap, 2))
    else $error("check enable changed without write");
  c_fatal: cover property (err_msg.fatal);
  c_cor: cover property (err_msg.cor);
  c_read: cover property (wb_ack_o && !wb_we_i);
endmodule : aer_regs_props
bind aer_severity_correctable_regs aer_regs_props #(.DOWNSTREAM_PORT(DOWNSTREAM_PORT)) i_props (
  .clk, .rst_n, .sticky_rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o,
  .wb_ack_o, .cor_evt, .unc_rpt, .err_msg, .ecrc_gen_en, .ecrc_chk_en);

// *** testbench/err_src_model.sv ***
`timescale 1ns/1ps
module err_src_model (
  input wire logic clk,
  output aer_pkg::cor_evt_t cor_evt,
  output logic [127:0] cor_hdr,
  output aer_pkg::unc_rpt_t unc_rpt,
  output logic unc_pending
);
  // idle: no events, header lines carry junk
  initial
  begin
    cor_evt = '0;
    cor_hdr = '1;
    unc_rpt = '{valid: 1'b0, pos: 5'h1f, hdr: '1};
    unc_pending = 1'b0;
  end
  // one-cycle detector pulse; header is junk once released
  task cor_pulse(input logic [5:0] bits);
    @(posedge clk);
    cor_evt <= aer_pkg::cor_evt_t'(bits);
    cor_hdr <= {16{8'ha5}};
    @(posedge clk);
    cor_evt <= '0;
    cor_hdr <= {16{8'h5a}};
  endtask : cor_pulse
  // uncorrectable report with header bytes base+k; pending stays up
  task unc_pulse(input logic [4:0] pos, input logic [7:0] base);
    logic [127:0] h;
    for (int k = 0; k < 16; k++) h[8*k +: 8] = base + 8'(k);
    @(posedge clk);
    unc_rpt <= '{valid: 1'b1, pos: pos, hdr: h};
    unc_pending <= 1'b1;
    @(posedge clk);
    unc_rpt <= '{valid: 1'b0, pos: ~pos, hdr: ~h};
  endtask : unc_pulse
endmodule : err_src_model

// *** testbench/tb.sv ***
`timescale 1ns/1ps
`include "aer_regs.svh"
module tb;
  logic clk, rst_n, sticky_rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq;
  logic ecrc_gen_en, ecrc_chk_en, unc_pending;
  logic [11:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [127:0] cor_hdr;
  aer_pkg::cor_evt_t cor_evt;
  aer_pkg::unc_rpt_t unc_rpt;
  aer_pkg::err_msg_t err_msg;
  int errors, checked, n_cor, n_nf, n_fat;
  typedef struct packed {logic we; logic [11:0] adr; logic [31:0] dat; logic [31:0] exp;} row_t;
  localparam row_t ROWS [14] = '{
    '{1'b0, `AER_OFF_SEV, 32'h0, 32'h00062031}, '{1'b0, `AER_OFF_CSTS, 32'h0, 32'h0},
    '{1'b0, `AER_OFF_CMSK, 32'h0, 32'h00002000}, '{1'b0, `AER_OFF_CAP, 32'h0, 32'h000000a0},
    '{1'b0, `AER_OFF_ISTS, 32'h0, 32'h0}, '{1'b1, `AER_OFF_SEV, 32'hffffffff, 32'h003ff031},
    '{1'b1, `AER_OFF_SEV, 32'h20, 32'h20}, '{1'b1, `AER_OFF_CMSK, 32'hffffffff, 32'h000031c1},
    '{1'b1, `AER_OFF_CMSK, 32'h0, 32'h0}, '{1'b1, `AER_OFF_CAP, 32'hffffffff, 32'h000001e0},
    '{1'b1, 12'h12c, 32'hffffffff, 32'h0}, '{1'b1, `AER_OFF_IMSK, 32'hffffffff, 32'hf},
    '{1'b1, `AER_OFF_CSTS, 32'hffffffff, 32'h0}, '{1'b1, `AER_OFF_HL0, 32'hffffffff, 32'h0}};
  aer_severity_correctable_regs i_aer_severity_correctable_regs (.clk, .rst_n, .sticky_rst_n,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .cor_evt, .cor_hdr, .unc_rpt, .unc_pending, .err_msg, .ecrc_gen_en, .ecrc_chk_en, .irq);
  err_src_model i_err_src_model (.clk, .cor_evt, .cor_hdr, .unc_rpt, .unc_pending);
  // clock and message pulse counting
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    if (err_msg.cor === 1'b1) n_cor++;
    if (err_msg.nonfatal === 1'b1) n_nf++;
    if (err_msg.fatal === 1'b1) n_fat++;
  end
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // one classic cycle; ack and read data are taken at the rising edge that ends it
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    @(posedge clk);
    while (wb_ack_o !== 1'b1) @(posedge clk);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : bus
  task rchk(input string what, input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, 4'hf);
    chk(what, rd, exp);
  endtask : rchk
  task test_done;
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : test_done
  // watchdog
  initial
  begin
    repeat (4000) @(posedge clk);
    errors++;
    test_done;
  end
  // main sequence
  initial
  begin
    {rst_n, sticky_rst_n, wb_cyc_i, wb_stb_i, wb_we_i} = '0;
    {wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    sticky_rst_n <= 1'b1;
    foreach (ROWS[i])
    begin
      if (ROWS[i].we) bus(1'b1, ROWS[i].adr, ROWS[i].dat, 4'hf);
      rchk($sformatf("row %0d", i), ROWS[i].adr, ROWS[i].exp);
    end
    $display("done: register table");
    for (int b = 0; b < 6; b++) i_err_src_model.cor_pulse(6'h20 >> b);
    rchk("cor status", `AER_OFF_CSTS, 32'h31c1);
    chk("cor msgs", n_cor, 6);
    @(negedge clk);
    chk("irq raised", irq, 1);
    bus(1'b1, `AER_OFF_CSTS, 32'hffffffff, 4'h1);
    rchk("byte clear", `AER_OFF_CSTS, 32'h3100);
    bus(1'b1, `AER_OFF_IMSK, 32'h0, 4'hf);
    @(negedge clk);
    chk("irq masked", irq, 0);
    bus(1'b1, `AER_OFF_ISTS, 32'hf, 4'hf);
    bus(1'b1, `AER_OFF_IMSK, 32'hf, 4'hf);
    @(negedge clk);
    chk("irq cleared", irq, 0);
    $display("done: events and interrupt");
    bus(1'b1, `AER_OFF_CMSK, 32'h31c1, 4'hf);
    i_err_src_model.cor_pulse(6'h3f);
    rchk("masked status", `AER_OFF_CSTS, 32'h31c1);
    chk("masked msgs", n_cor, 6);
    i_err_src_model.unc_pulse(5'h04, 8'h00);
    i_err_src_model.unc_pulse(5'h00, 8'h40);
    i_err_src_model.unc_pulse(5'h05, 8'h80);
    rchk("first pointer", `AER_OFF_CAP, 32'h1e4);
    rchk("log word 0", `AER_OFF_HL0, 32'h00010203);
    rchk("log word 3", `AER_OFF_HL3, 32'h0c0d0e0f);
    chk("nonfatal msgs", n_nf, 2);
    chk("fatal msgs", n_fat, 1);
    $display("done: uncorrectable reports");
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rchk("kept status", `AER_OFF_CSTS, 32'h31c1);
    rchk("kept control", `AER_OFF_CAP, 32'h1e4);
    @(negedge clk);
    chk("gen enable", ecrc_gen_en, 1);
    chk("chk enable", ecrc_chk_en, 1);
    sticky_rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    sticky_rst_n <= 1'b1;
    rchk("sev cleared", `AER_OFF_SEV, 32'h00062031);
    rchk("mask cleared", `AER_OFF_CMSK, 32'h2000);
    rchk("control cleared", `AER_OFF_CAP, 32'ha0);
    rchk("log cleared", `AER_OFF_HL0, 32'h0);
    @(negedge clk);
    chk("gen off", ecrc_gen_en, 0);
    $display("done: resets");
    test_done;
  end
endmodule : tb
